// file: inc/tsb_pkg.sv
package tsb_pkg;
    // register map, byte addresses
    localparam logic [11:0] TSB_ADDR_CTRL   = 12'h000;
    localparam logic [11:0] TSB_ADDR_STATUS = 12'h004;
    localparam logic [7:0]  TSB_CTRL_RST    = 8'h00;

    // control fields: per-level filter enables then unit controls
    localparam int TSB_CTRL_USER_EN  = 0;
    localparam int TSB_CTRL_KERN_EN  = 1;
    localparam int TSB_CTRL_HYP_EN   = 2;
    localparam int TSB_CTRL_HUSER_EN = 3;
    localparam int TSB_CTRL_UNIT_EN  = 4;
    localparam int TSB_CTRL_OSLOCK   = 5;
    localparam int TSB_CTRL_CTX_EN   = 6;
    localparam int TSB_CTRL_TS_EN    = 7;

    // status fields
    localparam int TSB_ST_BUSY   = 0;
    localparam int TSB_ST_QUIET  = 1;
    localparam int TSB_ST_FLUSH  = 2;
    localparam int TSB_ST_FIN    = 3;
    localparam int TSB_ST_CMPL   = 4;
    localparam int TSB_ST_TMO    = 5;
    localparam int TSB_ST_UNFIN  = 8;
    localparam int TSB_ST_INCMPL = 16;

    // operation counters
    localparam int TSB_CNT_W = 8;

    // bound on accept, discard or reject of trace data
    localparam int TSB_CLK_PERIOD_PS   = 5000;
    localparam int TSB_RESOLVE_NS      = 1000;
    localparam int TSB_RESOLVE_CYC     =
        (TSB_RESOLVE_NS * 1000) / TSB_CLK_PERIOD_PS;
    localparam int TSB_TMO_W = 11;

    // who a register access belongs to
    typedef enum logic [2:0] {
        TSB_ACC_NONE  = 3'b000,
        TSB_ACC_INSTR = 3'b001,
        TSB_ACC_OP    = 3'b010,
        TSB_ACC_OTHER = 3'b100
    } tsb_acc_t;

    // barrier sequencer
    typedef enum logic [1:0] {
        TSB_B_IDLE  = 2'b01,
        TSB_B_DRAIN = 2'b10
    } tsb_bst_t;
endpackage : tsb_pkg

// file: design/tsb_ctrl.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - trace operations run decoupled; their register accesses are external
// RULE2 - filter enable reads for the trace decision belong to the instruction
// RULE3 - each trace register access is tagged instruction, operation or other
// RULE4 - instruction also reads unit enable and os lock to decide on tracing
// RULE5 - operation reads context id and counter offset when those are enabled
// RULE6 - buffer writer register accesses belong to the operation in progress
// RULE7 - software issues the barrier to synchronise trace with execution
// RULE8 - trace data is accepted, discarded or rejected within bounded time
// RULE9 - memory write and register effects need explicit sync to complete
// RULE10 - executing the barrier raises a trace synchronisation event
// RULE11 - operation finished only when all its indirect accesses performed
// RULE12 - operation starting a flush finishes after flush and its writes end
// RULE13 - finishing does not wait for external abort register writes
// RULE14 - complete means finished, memory done and abort writes performed
// RULE15 - barrier in prohibited region waits for earlier operations to finish
// RULE16 - before barrier ends trace unit goes quiet while region prohibited
// RULE17 - a flush started before barrier end must complete before it ends
// RULE18 - register writes after barrier ordered after earlier trace accesses
// RULE19 - barrier never waits for an empty pipeline under continuous trace
// RULE20 - unfinished barrier may be abandoned for an interrupt, then reruns
// RULE21 - barrier otherwise unordered; software adds barriers as needed
// RULE22 - writer reports when all accepted operations are finished
module tsb_ctrl (
    // clock and reset
    input  wire  logic                  clk_in,
    input  wire  logic                  arst_n_in,
    // apb slave
    input  wire  logic                  psel_in,
    input  wire  logic                  penable_in,
    input  wire  logic                  pwrite_in,
    input  wire  logic [11:0]           paddr_in,
    input  wire  logic [31:0]           pwdata_in,
    output logic       [31:0]           prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // pipeline side
    input  wire  logic                  instr_valid_in,
    input  wire  logic [1:0]            instr_level_in,
    input  wire  logic                  ctx_sync_in,
    input  wire  logic                  prohibited_in,
    input  wire  logic                  debug_state_in,
    input  wire  logic                  barrier_in,
    input  wire  logic                  irq_in,
    output logic                        barrier_busy_out,
    output logic                        barrier_retire_out,
    output logic                        barrier_abandon_out,
    output logic                        sync_event_out,
    // trace unit side
    input  wire  logic                  resource_acc_in,
    input  wire  logic                  trigger_in,
    output logic                        trace_op_out,
    output logic                        ctx_id_rd_out,
    output logic                        cnt_off_rd_out,
    output tsb_pkg::tsb_acc_t           acc_class_out,
    output logic                        quiet_out,
    // buffer writer side
    input  wire  logic                  writer_acc_in,
    input  wire  logic                  op_accept_in,
    input  wire  logic                  op_drop_in,
    input  wire  logic                  op_fin_in,
    input  wire  logic                  op_cmpl_in,
    input  wire  logic                  flush_done_in,
    output logic                        all_fin_out,
    output logic                        all_cmpl_out,
    output logic                        resolve_tmo_out
);
    import tsb_pkg::*;

    localparam logic [TSB_CNT_W-1:0] CNT_ONE = {{(TSB_CNT_W-1){1'b0}}, 1'b1};
    localparam logic [TSB_CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [TSB_TMO_W-1:0] TMO_LIMIT =
        TSB_TMO_W'(TSB_RESOLVE_CYC);

    typedef struct packed {
        logic [7:0]           ctrl;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        logic                 trace_op;
        logic                 ctx_rd;
        logic                 cnt_rd;
        tsb_acc_t             acc;
        logic                 sync_ev;
        logic                 busy;
        logic                 retire;
        logic                 abandon;
        logic                 quiet;
        logic                 all_fin;
        logic                 all_cmpl;
        logic                 tmo;
        logic                 prohib_mode;
        logic                 flushing;
        logic [TSB_CNT_W-1:0] unres;
        logic [TSB_CNT_W-1:0] unfin;
        logic [TSB_CNT_W-1:0] incmpl;
        logic [TSB_CNT_W-1:0] pre_cse;
        logic [TSB_TMO_W-1:0] tmo_cnt;
        tsb_bst_t             bst;
    } tsb_state_t;

    tsb_state_t st_reg;
    tsb_state_t st_next;

    logic       filt_ok;
    logic       gen;
    logic       fin;
    logic       apb_setup;
    logic       apb_done;
    logic       hit_ctrl;
    logic       hit_status;
    logic       trig_seen;
    logic [31:0] status_word;

    // trace decision reads filter, enable and os lock for this instruction
    always_comb begin
        unique case (instr_level_in)
            2'd0:    filt_ok = st_reg.ctrl[TSB_CTRL_USER_EN];   // RULE2
            2'd1:    filt_ok = st_reg.ctrl[TSB_CTRL_KERN_EN];   // RULE2
            2'd2:    filt_ok = st_reg.ctrl[TSB_CTRL_HYP_EN];    // RULE2
            default: filt_ok = st_reg.ctrl[TSB_CTRL_HUSER_EN];  // RULE2
        endcase
    end

    // a quiet unit makes no operations and ignores triggers
    assign gen = instr_valid_in && filt_ok && !st_reg.quiet
               && st_reg.ctrl[TSB_CTRL_UNIT_EN]                 // RULE4
               && !st_reg.ctrl[TSB_CTRL_OSLOCK];                // RULE4
    assign trig_seen = trigger_in && !st_reg.quiet;             // RULE16
    // a dropped operation has nothing left to perform
    assign fin = op_fin_in || op_drop_in;                       // RULE11

    // apb decode; answer one cycle into the access phase
    // the wait state buys a pready that comes from a flop
    assign apb_setup  = psel_in && penable_in && !st_reg.pready;
    assign apb_done   = psel_in && penable_in && st_reg.pready;
    assign hit_ctrl   = paddr_in == TSB_ADDR_CTRL;
    assign hit_status = paddr_in == TSB_ADDR_STATUS;

    always_comb begin
        status_word = '0;
        status_word[TSB_ST_BUSY]  = st_reg.busy;
        status_word[TSB_ST_QUIET] = st_reg.quiet;
        status_word[TSB_ST_FLUSH] = st_reg.flushing;
        status_word[TSB_ST_FIN]   = st_reg.all_fin;
        status_word[TSB_ST_CMPL]  = st_reg.all_cmpl;
        status_word[TSB_ST_TMO]   = st_reg.tmo;
        status_word[TSB_ST_UNFIN +: TSB_CNT_W]  = st_reg.unfin;
        status_word[TSB_ST_INCMPL +: TSB_CNT_W] = st_reg.incmpl;
    end

    // whole next state
    always_comb begin
        st_next = st_reg;
        st_next.retire  = 1'b0;
        st_next.abandon = 1'b0;
        st_next.sync_ev = 1'b0;

        // register bus
        if (apb_setup) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = !(hit_ctrl || hit_status);
            st_next.prdata  = hit_ctrl ? {24'h000000, st_reg.ctrl}
                            : hit_status ? status_word : 32'h00000000;
        end else if (apb_done) begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h00000000;
        end
        if (apb_done && pwrite_in && hit_ctrl) begin
            st_next.ctrl = pwdata_in[7:0];
        end

        // operation launch and its own register reads
        st_next.trace_op = gen;
        st_next.ctx_rd = gen && st_reg.ctrl[TSB_CTRL_CTX_EN];   // RULE5
        st_next.cnt_rd = gen && st_reg.ctrl[TSB_CTRL_TS_EN];    // RULE5

        // ownership of each access, instruction first
        if (instr_valid_in) begin
            st_next.acc = TSB_ACC_INSTR;                        // RULE3
        end else if (writer_acc_in) begin
            st_next.acc = TSB_ACC_OP;                           // RULE6
        end else if (resource_acc_in) begin
            st_next.acc = TSB_ACC_OTHER;                        // RULE3
        end else begin
            st_next.acc = TSB_ACC_NONE;
        end

        // bookkeeping runs apart from the pipeline
        st_next.unres = st_reg.unres + (gen ? CNT_ONE : CNT_ZERO)
                      - ((op_accept_in || op_drop_in) ? CNT_ONE
                                                      : CNT_ZERO); // RULE1
        st_next.unfin = st_reg.unfin + (gen ? CNT_ONE : CNT_ZERO)
                      - (fin ? CNT_ONE : CNT_ZERO);             // RULE11
        // abort writes only gate completion, never finishing
        st_next.incmpl = st_reg.incmpl
                       + (op_accept_in ? CNT_ONE : CNT_ZERO)
                       - (op_cmpl_in ? CNT_ONE : CNT_ZERO);     // RULE13

        // flush holds finishing until its end writes are done
        if (trig_seen) begin
            st_next.flushing = 1'b1;                            // RULE12
        end else if (flush_done_in) begin
            st_next.flushing = 1'b0;                            // RULE12
        end

        // bounded resolution watchdog; set wins over clear
        if (st_reg.unres == CNT_ZERO || op_accept_in || op_drop_in) begin
            st_next.tmo_cnt = '0;
        end else if (st_reg.tmo_cnt != TMO_LIMIT) begin
            st_next.tmo_cnt = st_reg.tmo_cnt + 1'b1;
        end
        if (st_reg.tmo_cnt == TMO_LIMIT) begin
            st_next.tmo = 1'b1;                                 // RULE8
        end else if (apb_done && pwrite_in && hit_status
                     && pwdata_in[TSB_ST_TMO]) begin
            st_next.tmo = 1'b0;
        end

        // only operations up to the sync event are waited for
        if (ctx_sync_in) begin
            st_next.pre_cse = st_next.unfin;                    // RULE19
            st_next.prohib_mode = prohibited_in && !debug_state_in;
        end else if (fin && st_reg.pre_cse != CNT_ZERO) begin
            st_next.pre_cse = st_reg.pre_cse - CNT_ONE;
        end

        // quiet lasts while execution stays prohibited
        if (!prohibited_in) begin
            st_next.quiet = 1'b0;                               // RULE16
        end

        // barrier sequencer
        unique case (st_reg.bst)
            TSB_B_IDLE: begin
                if (barrier_in) begin
                    st_next.sync_ev = 1'b1;                     // RULE10
                    st_next.busy    = 1'b1;                     // RULE18
                    st_next.bst     = TSB_B_DRAIN;
                    if (st_reg.prohib_mode && prohibited_in) begin
                        st_next.quiet = 1'b1;                   // RULE16
                    end
                end
            end
            TSB_B_DRAIN: begin
                if (irq_in && !debug_state_in) begin
                    st_next.abandon = 1'b1;                     // RULE20
                    st_next.busy    = 1'b0;
                    st_next.bst     = TSB_B_IDLE;
                end else if (st_reg.pre_cse == CNT_ZERO          // RULE15
                             && !st_reg.flushing                // RULE17
                             && !trig_seen) begin
                    st_next.retire = 1'b1;                      // RULE21
                    st_next.busy   = 1'b0;
                    st_next.bst    = TSB_B_IDLE;
                end
            end
        endcase

        // summary for the pipeline; completion needs explicit sync
        st_next.all_fin  = st_next.unfin == CNT_ZERO
                         && !st_next.flushing;                  // RULE22
        st_next.all_cmpl = st_next.all_fin
                         && st_next.incmpl == CNT_ZERO;         // RULE9 RULE14
    end

    // single state register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg          <= '0;
            st_reg.ctrl     <= TSB_CTRL_RST;
            st_reg.acc      <= TSB_ACC_NONE;
            st_reg.bst      <= TSB_B_IDLE;
            st_reg.all_fin  <= 1'b1;
            st_reg.all_cmpl <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prdata_out          = st_reg.prdata;
    assign pready_out          = st_reg.pready;
    assign pslverr_out         = st_reg.pslverr;
    assign barrier_busy_out    = st_reg.busy;
    assign barrier_retire_out  = st_reg.retire;
    assign barrier_abandon_out = st_reg.abandon;
    assign sync_event_out      = st_reg.sync_ev;
    assign trace_op_out        = st_reg.trace_op;
    assign ctx_id_rd_out       = st_reg.ctx_rd;
    assign cnt_off_rd_out      = st_reg.cnt_rd;
    assign acc_class_out       = st_reg.acc;
    assign quiet_out           = st_reg.quiet;
    assign all_fin_out         = st_reg.all_fin;
    assign all_cmpl_out        = st_reg.all_cmpl;
    assign resolve_tmo_out     = st_reg.tmo;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // barrier start raises the event and holds the pipeline
    a_barrier_event: assert property (                          // RULE10
        st_reg.bst == TSB_B_IDLE && barrier_in
        |=> sync_event_out && barrier_busy_out)
        else $error("barrier did not raise sync event");

    // quiet unit launches nothing
    a_quiet_no_op: assert property (                            // RULE16
        st_reg.quiet && instr_valid_in |=> !trace_op_out)
        else $error("operation launched while quiet");

    // filter bit off blocks the operation
    a_filter_gate: assert property (                            // RULE2
        instr_valid_in && !filt_ok |=> !trace_op_out)
        else $error("operation launched with filter off");

    // enable and os lock both gate the operation
    a_enable_gate: assert property (                            // RULE4
        trace_op_out |-> $past(st_reg.ctrl[TSB_CTRL_UNIT_EN])
                         && !$past(st_reg.ctrl[TSB_CTRL_OSLOCK]))
        else $error("operation launched while disabled or locked");

    // context read follows the context enable
    a_ctx_read: assert property (                               // RULE5
        trace_op_out |-> ctx_id_rd_out
                         == $past(st_reg.ctrl[TSB_CTRL_CTX_EN]))
        else $error("context read does not match enable");

    // no retire while a flush is open
    a_flush_blocks: assert property (                           // RULE17
        st_reg.flushing && !flush_done_in ##1 st_reg.flushing
        |=> !barrier_retire_out)
        else $error("barrier retired during flush");

    // retire only once earlier operations drained
    a_retire_drained: assert property (                         // RULE15
        barrier_retire_out |-> $past(st_reg.pre_cse) == CNT_ZERO
                               && $past(barrier_busy_out))
        else $error("barrier retired with earlier work open");

    // interrupt abandons an unfinished barrier next cycle
    a_irq_abandon: assert property (                            // RULE20
        barrier_busy_out && irq_in && !debug_state_in
        |=> barrier_abandon_out && !barrier_busy_out)
        else $error("barrier not abandoned on interrupt");

    // debug state keeps a barrier through interrupts
    a_debug_hold: assert property (  // RULE20
        barrier_busy_out && irq_in && debug_state_in
        |=> !barrier_abandon_out)
        else $error("barrier abandoned in debug state");

    // more than one unfinished operation blocks the finished flag next cycle
    a_fin_flag: assert property (                               // RULE22
        st_reg.unfin > CNT_ONE |=> !all_fin_out)
        else $error("finished flag with operations open");

    // complete never runs ahead of finished
    a_cmpl_flag: assert property (                              // RULE14
        all_cmpl_out |-> all_fin_out)
        else $error("complete without finished");

    // watchdog flags an unresolved operation in time
    a_resolve_tmo: assert property (                            // RULE8
        st_reg.tmo_cnt == TMO_LIMIT |=> resolve_tmo_out)
        else $error("resolution timeout not flagged");
endmodule : tsb_ctrl

// file: verification/tsb_writer_model.sv
`timescale 1ns/1ps
// behavioural buffer writer: every third op is discarded, others finish later
module tsb_writer_model (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    // from the block and the bench
    input  wire logic trace_op_in,
    input  wire logic flush_req_in,
    input  wire logic stall_in,
    // writer responses
    output logic      op_accept_out,
    output logic      op_drop_out,
    output logic      op_fin_out,
    output logic      op_cmpl_out,
    output logic      flush_done_out,
    output logic      writer_acc_out
);
    int   pend, unfin, incmpl, seq, fl_cnt;
    logic fl_go;

    // stall holds back finishes, completions and flush ends but not accept or discard, so a slow writer still decides quickly
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {op_accept_out, op_drop_out, op_fin_out} <= 3'h0;
            {op_cmpl_out, flush_done_out, writer_acc_out} <= 3'h0;
            pend = 0;
            unfin = 0;
            incmpl = 0;
            seq = 0;
            fl_cnt = 0;
        end else begin
            fl_go = !stall_in && fl_cnt == 1 && unfin == 0;
            op_accept_out <= pend > 0 && seq % 3 != 2;
            op_drop_out <= pend > 0 && seq % 3 == 2;
            op_fin_out <= !stall_in && unfin > 0;
            writer_acc_out <= !stall_in && unfin > 0;
            op_cmpl_out <= !stall_in && incmpl > 0;
            flush_done_out <= fl_go;
            if (!stall_in && incmpl > 0) incmpl--;
            if (!stall_in && unfin > 0) begin
                unfin--;
                incmpl++;
            end
            if (pend > 0) begin
                if (seq % 3 != 2) unfin++;
                seq++;
                pend--;
            end
            pend += trace_op_in;
            if (flush_req_in) fl_cnt = 6;
            else if (!stall_in && fl_cnt > 1) fl_cnt--;
            else if (fl_go) fl_cnt = 0;
        end
    end
endmodule : tsb_writer_model

// file: verification/tb_trace_sync_barrier_control.sv
`timescale 1ns/1ps
module tb_trace_sync_barrier_control;
    import tsb_pkg::*;
    logic        clk_in, arst_n_in, psel, penable, pwrite, iv, ctx_s, proh;
    logic        bar_in, irq, res_acc, trig, stall, w_d, dbg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  lvl;
    logic        pready, pslverr, busy, retire, abandon, sync_ev, trace_op;
    logic        ctx_rd, cnt_rd, quiet, all_fin, all_cmpl, tmo;
    logic        acc, drop, fin, cmpl, fl_done, wacc;
    tsb_acc_t    acc_class;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [7:0]  c;
    int          miscompares, check_count, cycles, n, seed;

    tsb_ctrl tsb_ctrl_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .instr_valid_in(iv), .instr_level_in(lvl),
        .ctx_sync_in(ctx_s), .prohibited_in(proh), .debug_state_in(dbg),
        .barrier_in(bar_in), .irq_in(irq), .barrier_busy_out(busy),
        .barrier_retire_out(retire), .barrier_abandon_out(abandon),
        .sync_event_out(sync_ev), .resource_acc_in(res_acc),
        .trigger_in(trig), .trace_op_out(trace_op), .ctx_id_rd_out(ctx_rd),
        .cnt_off_rd_out(cnt_rd), .acc_class_out(acc_class),
        .quiet_out(quiet), .writer_acc_in(wacc), .op_accept_in(acc),
        .op_drop_in(drop), .op_fin_in(fin), .op_cmpl_in(cmpl),
        .flush_done_in(fl_done), .all_fin_out(all_fin),
        .all_cmpl_out(all_cmpl), .resolve_tmo_out(tmo));

    tsb_writer_model tsb_writer_model_i (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .trace_op_in(trace_op),
        .flush_req_in(trig), .stall_in(stall), .op_accept_out(acc),
        .op_drop_out(drop), .op_fin_out(fin), .op_cmpl_out(cmpl),
        .flush_done_out(fl_done), .writer_acc_out(wacc));

    always #2.5 clk_in = ~clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // expectation {is_read, err, data} is queued before the request goes out
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] x);
        exp_q.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            @(posedge clk_in);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask : apb

    // one instruction; q says the unit should be quiet
    task automatic instr(input logic [1:0] l, input logic [7:0] k,
                         input logic q);
        logic x;
        x = k[l] && k[TSB_CTRL_UNIT_EN] && !k[TSB_CTRL_OSLOCK] && !q;
        iv <= 1'b1;
        lvl <= l;
        @(posedge clk_in);
        iv <= 1'b0;
        @(posedge clk_in);
        check(32'(trace_op), 32'(x));
        check(32'(ctx_rd), 32'(x && k[TSB_CTRL_CTX_EN]));
        check(32'(cnt_rd), 32'(x && k[TSB_CTRL_TS_EN]));
        if (x) check(32'(acc_class), 32'(TSB_ACC_INSTR));
    endtask : instr

    task automatic ctx();
        ctx_s <= 1'b1;
        @(posedge clk_in);
        ctx_s <= 1'b0;
        @(posedge clk_in);
    endtask : ctx

    // issue the barrier, count cycles until retire or abandon
    task automatic bar(output int m);
        bar_in <= 1'b1;
        @(posedge clk_in);
        bar_in <= 1'b0;
        @(posedge clk_in);
        check(32'(sync_ev), 32'h1);
        check(32'(busy), 32'h1);
        m = 1;
        while (retire !== 1'b1 && abandon !== 1'b1 && m < 300) begin
            @(posedge clk_in);
            m++;
        end
    endtask : bar

    // read answers and writer-access class are checked as they appear
    always @(posedge clk_in) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(32'(pslverr), 32'(e[32]));
            if (e[33]) check(prdata, e[31:0]);
        end
        if (w_d) check(32'(acc_class), 32'(TSB_ACC_OP));
        w_d = wacc && !iv && !res_acc;
        cycles++;
        if (cycles > 4000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        {clk_in, arst_n_in, psel, penable, pwrite, iv, ctx_s, proh} = 8'h0;
        {bar_in, irq, res_acc, trig, stall, w_d, dbg} = 7'h0;
        {paddr, pwdata, lvl} = 46'h0;
        {miscompares, check_count, cycles, n} = 128'h0;
        seed = 78186;
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        check(32'(all_fin), 32'h1);
        check(32'(all_cmpl), 32'h1);
        apb(1'b0, TSB_ADDR_CTRL, 32'h0, {2'b10, 24'h0, TSB_CTRL_RST});
        apb(1'b0, TSB_ADDR_STATUS, 32'h0, {2'b10, 32'h18});
        apb(1'b0, 12'h008, 32'h0, {2'b11, 32'h0});
        apb(1'b1, 12'h00c, 32'h5a, {2'b01, 32'h0});
        $display("test registers done");
        // random gating; half the runs force unit on and lock off
        for (int i = 0; i < 24; i++) begin
            c = 8'($random(seed));
            if (i % 2 == 1) c = (c | 8'h10) & 8'hdf;
            apb(1'b1, TSB_ADDR_CTRL, {24'h0, c}, {2'b00, 32'h0});
            apb(1'b0, TSB_ADDR_CTRL, 32'h0, {2'b10, 24'h0, c});
            instr(2'($random(seed)), c, 1'b0);
        end
        res_acc <= 1'b1;
        @(posedge clk_in);
        res_acc <= 1'b0;
        @(posedge clk_in);
        check(32'(acc_class), 32'(TSB_ACC_OTHER));
        $display("test gating done");
        // ops after the sync point must not hold the barrier
        apb(1'b1, TSB_ADDR_CTRL, 32'h1f, {2'b00, 32'h0});
        repeat (20) @(posedge clk_in);
        ctx();
        stall <= 1'b1;
        instr(2'h0, 8'h1f, 1'b0);
        instr(2'h1, 8'h1f, 1'b0);
        repeat (4) @(posedge clk_in);
        bar(n);
        check(n, 2);
        check(32'(busy), 32'h0);
        check(32'(all_fin), 32'h0);
        $display("test no_wait done");
        // prohibited region: barrier waits for earlier ops, unit goes quiet
        proh <= 1'b1;
        ctx();
        fork
            bar(n);
            begin
                repeat (4) @(posedge clk_in);
                check(32'(quiet), 32'h1);
                instr(2'h2, 8'h1f, 1'b1);
                repeat (6) @(posedge clk_in);
                stall <= 1'b0;
            end
        join
        check(32'(n > 10), 32'h1);
        check(32'(retire), 32'h1);
        repeat (20) @(posedge clk_in);
        check(32'(all_cmpl), 32'h1);
        check(32'(quiet), 32'h1);
        proh <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(32'(quiet), 32'h0);
        $display("test prohibited done");
        // a flush started before the barrier ends must close first
        ctx();
        trig <= 1'b1;
        {irq, dbg} <= 2'h3;
        @(posedge clk_in);
        trig <= 1'b0;
        bar(n);
        check(32'(n >= 5 && n < 300), 32'h1);
        check(32'(retire), 32'h1);
        {irq, dbg} <= 2'h0;
        $display("test flush done");
        // interrupt drops a waiting barrier
        stall <= 1'b1;
        instr(2'h3, 8'h1f, 1'b0);
        instr(2'h0, 8'h1f, 1'b0);
        repeat (4) @(posedge clk_in);
        ctx();
        fork
            bar(n);
            begin
                repeat (4) @(posedge clk_in);
                irq <= 1'b1;
            end
        join
        check(32'(abandon), 32'h1);
        check(32'(busy), 32'h0);
        irq <= 1'b0;
        stall <= 1'b0;
        repeat (30) @(posedge clk_in);
        check(32'(tmo), 32'h0);
        apb(1'b0, TSB_ADDR_STATUS, 32'h0, {2'b10, 32'h18});
        $display("test abandon done");
        finish_test();
    end
endmodule : tb_trace_sync_barrier_control
